//--- core/uart_line_core.sv
// uart control, line status, holding registers and interrupt logic
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// How it works
// R01: bits 7:6 pick lin or pin five
// R02: loopback bit holds transmit pin high
// R03: fully empty sets idle, clears on write
// R04: holding empty sets, clears on write
// R05: long low line sets break flag
// R06: bad stop bit sets framing flag
// R07: failed parity check sets parity flag
// R08: unread character overwritten sets overrun flag
// R09: data ready until holding register read
// R10: line status has top ident, read clears
// R11: enabled error bits raise line interrupt
// R12: error flags held until status read
module uart_line_core
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata_q,
  input  wire logic        lin_rx_pin,
  input  wire logic        general_pin_five,
  output logic             tx_pin_q,
  output logic             irq_q
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] lin_sync_q;
  logic [1:0] gp5_sync_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lin_sync_q <= 2'h3;
      gp5_sync_q <= 2'h3;
    end
    else
    begin
      lin_sync_q <= {lin_sync_q[0], lin_rx_pin};
      gp5_sync_q <= {gp5_sync_q[0], general_pin_five};
    end
  end

  // ****************************************
  // access decode
  // ****************************************
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_hold;
  logic rd_hold;
  logic rd_status;

  assign wr_hold   = wr_en && hit(addr, uart_pkg::HOLDING_OFS);
  assign rd_hold   = rd_en && hit(addr, uart_pkg::HOLDING_OFS);
  assign rd_status = rd_en && hit(addr, uart_pkg::LINE_STATUS_OFS);

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0]  uart_control_two_q;
  logic [4:0]  line_ctrl_q;
  logic [15:0] divisor_q;
  logic [2:0]  irq_mask_q;
  logic        loopback;
  logic [1:0]  rx_source_select;

  assign loopback         = uart_control_two_q[uart_pkg::LOOPBACK_BIT];
  assign rx_source_select = uart_control_two_q[uart_pkg::SRC_SEL_LSB +: 2];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uart_control_two_q <= uart_pkg::CONTROL_TWO_RST;
      line_ctrl_q        <= uart_pkg::LINE_CTRL_RST;
      divisor_q          <= uart_pkg::DIVISOR_RST;
      irq_mask_q         <= 3'h0;
    end
    else if (wr_en)
    begin
      if (hit(addr, uart_pkg::CONTROL_TWO_OFS))
        uart_control_two_q <= wdata[7:0] & 8'hd0;
      if (hit(addr, uart_pkg::LINE_CTRL_OFS))
        line_ctrl_q <= wdata[4:0];
      if (hit(addr, uart_pkg::DIVISOR_OFS))
        divisor_q <= wdata[15:0];
      if (hit(addr, uart_pkg::IRQ_MASK_OFS))
        irq_mask_q <= wdata[2:0];
    end
  end

  // ****************************************
  // oversample tick generator
  // ****************************************
  logic [15:0] baud_cnt_q;
  logic        tick_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (baud_cnt_q + 16'h0001 >= divisor_q)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  logic [7:0] tx_holding_reg_q;
  logic       tx_full_q;
  logic       tx_load;
  logic       tx_busy;
  logic       tx_serial;

  assign tx_load = tx_full_q && !tx_busy;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_holding_reg_q <= 8'h00;
      tx_full_q        <= 1'b0;
    end
    else if (wr_hold)
    begin
      tx_holding_reg_q <= wdata[7:0];
      tx_full_q        <= 1'b1; // R03 R04
    end
    else if (tx_load)
      tx_full_q <= 1'b0;
  end

  uart_tx_shift u_tx
  (
    .clk         (clk),
    .reset_n     (reset_n),
    .tick        (tick_q),
    .load        (tx_load),
    .data        (tx_holding_reg_q),
    .parity_en   (line_ctrl_q[uart_pkg::PARITY_EN_BIT]),
    .parity_even (line_ctrl_q[uart_pkg::PARITY_EVEN_BIT]),
    .two_stop    (line_ctrl_q[uart_pkg::TWO_STOP_BIT]),
    .serial_q    (tx_serial),
    .busy_q      (tx_busy)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_pin_q <= 1'b1;
    else
      tx_pin_q <= loopback ? 1'b1 : tx_serial; // R02
  end

  // ****************************************
  // receive path
  // ****************************************
  logic                 rx_in;
  uart_pkg::rx_result_s rx_result;
  logic                 rx_valid;
  logic                 rx_break;

  always_comb
  begin
    if (loopback)
      rx_in = tx_serial;
    else if (rx_source_select == uart_pkg::SRC_LIN)
      rx_in = lin_sync_q[1]; // R01
    else if (rx_source_select == uart_pkg::SRC_GP5)
      rx_in = gp5_sync_q[1]; // R01
    else
      rx_in = 1'b1;
  end

  uart_rx_frame u_rx
  (
    .clk         (clk),
    .reset_n     (reset_n),
    .tick        (tick_q),
    .serial_in   (rx_in),
    .parity_en   (line_ctrl_q[uart_pkg::PARITY_EN_BIT]),
    .parity_even (line_ctrl_q[uart_pkg::PARITY_EVEN_BIT]),
    .result_q    (rx_result),
    .valid_q     (rx_valid),
    .break_q     (rx_break)
  );

  // ****************************************
  // line status flags
  // ****************************************
  logic [7:0] rx_holding_reg_q;
  logic       ready_q;
  logic       overrun_q;
  logic       framing_q;
  logic       parity_q;
  logic       break_q;
  logic       overrun_evt;

  assign overrun_evt = rx_valid && ready_q && !rd_hold;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_holding_reg_q <= 8'h00;
      ready_q          <= 1'b0;
    end
    else if (rx_valid)
    begin
      rx_holding_reg_q <= rx_result.data;
      ready_q          <= 1'b1; // R09
    end
    else if (rd_hold)
      ready_q <= 1'b0; // R09
  end

  // errors stay until a status read; a new event beats the read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
      parity_q  <= 1'b0;
      break_q   <= 1'b0;
    end
    else
    begin
      overrun_q <= overrun_evt || (overrun_q && !rd_status); // R08 R10 R12
      framing_q <= (rx_valid && rx_result.framing_fault) || (framing_q && !rd_status); // R06 R12
      parity_q  <= (rx_valid && rx_result.parity_fault) || (parity_q && !rd_status); // R07 R12
      break_q   <= rx_break || (break_q && !rd_status); // R05
    end
  end

  uart_pkg::line_status_s uart_line_status;
  logic                   line_err;

  always_comb
  begin
    uart_line_status                         = '0;
    uart_line_status.transmitter_fully_empty = !tx_full_q && !tx_busy; // R03
    uart_line_status.tx_holding_empty        = !tx_full_q; // R04
    uart_line_status.break_seen              = break_q;
    uart_line_status.framing_fault           = framing_q;
    uart_line_status.parity_fault            = parity_q;
    uart_line_status.overrun_fault           = overrun_q;
    uart_line_status.rx_data_ready           = ready_q;
  end

  assign line_err = framing_q || parity_q || overrun_q || break_q;

  // ****************************************
  // interrupt status, mask and ident
  // ****************************************
  logic [2:0] irq_status_q;
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;
  logic [2:0] ident;

  assign irq_evt = {tx_load, rx_valid, overrun_evt || rx_break || (rx_valid && |rx_result[1:0])};
  assign irq_clr = (wr_en && hit(addr, uart_pkg::IRQ_STATUS_OFS)) ? wdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_status_q <= 3'h0;
    else
      irq_status_q <= irq_evt | (irq_status_q & ~irq_clr);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_status_q & irq_mask_q) || (irq_mask_q[uart_pkg::IRQ_LINE] && line_err); // R11
  end

  always_comb
  begin
    if (line_err && irq_mask_q[uart_pkg::IRQ_LINE])
      ident = uart_pkg::IDENT_LINE; // R10
    else if (ready_q && irq_mask_q[uart_pkg::IRQ_RX])
      ident = uart_pkg::IDENT_RX;
    else if (!tx_full_q && irq_mask_q[uart_pkg::IRQ_TX])
      ident = uart_pkg::IDENT_TX;
    else
      ident = uart_pkg::IDENT_NONE;
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 32'h0000_0000;
    else if (!rd_en)
      rdata_q <= 32'h0000_0000;
    else
      case (addr)
        uart_pkg::HOLDING_OFS:     rdata_q <= {24'h00_0000, rx_holding_reg_q};
        uart_pkg::DIVISOR_OFS:     rdata_q <= {16'h0000, divisor_q};
        uart_pkg::IDENT_OFS:       rdata_q <= {29'h0000_0000, ident};
        uart_pkg::LINE_CTRL_OFS:   rdata_q <= {27'h000_0000, line_ctrl_q};
        uart_pkg::CONTROL_TWO_OFS: rdata_q <= {24'h00_0000, uart_control_two_q};
        uart_pkg::LINE_STATUS_OFS: rdata_q <= {24'h00_0000, uart_line_status};
        uart_pkg::IRQ_STATUS_OFS:  rdata_q <= {29'h0000_0000, irq_status_q};
        uart_pkg::IRQ_MASK_OFS:    rdata_q <= {29'h0000_0000, irq_mask_q};
        default:                   rdata_q <= 32'h0000_0000;
      endcase
  end

  // ****************************************
  // checks
  // ****************************************
  property p_src_lin;
    @(posedge clk) disable iff (!reset_n)
    (!loopback && rx_source_select == uart_pkg::SRC_LIN) |-> rx_in == lin_sync_q[1];
  endproperty
  a_src_lin: assert property (p_src_lin) else $error("rx source not lin"); // R01

  property p_loop_high;
    @(posedge clk) disable iff (!reset_n)
    loopback [*2] |-> tx_pin_q;
  endproperty
  a_loop_high: assert property (p_loop_high) else $error("tx pin low in loopback"); // R02

  property p_transmitter_fully_empty_write;
    @(posedge clk) disable iff (!reset_n)
    wr_hold |=> !uart_line_status.transmitter_fully_empty && !uart_line_status.tx_holding_empty;
  endproperty
  a_transmitter_fully_empty_write: assert property (p_transmitter_fully_empty_write) else $error("empty flags after write"); // R03

  property p_tx_holding_empty_set;
    @(posedge clk) disable iff (!reset_n)
    (tx_load && !wr_hold) |=> uart_line_status.tx_holding_empty;
  endproperty
  a_tx_holding_empty_set: assert property (p_tx_holding_empty_set) else $error("holding empty not set"); // R04

  property p_break;
    @(posedge clk) disable iff (!reset_n)
    rx_break |=> uart_line_status.break_seen;
  endproperty
  a_break: assert property (p_break) else $error("break not flagged"); // R05

  property p_framing;
    @(posedge clk) disable iff (!reset_n)
    (rx_valid && rx_result.framing_fault) |=> framing_q;
  endproperty
  a_framing: assert property (p_framing) else $error("framing not flagged"); // R06

  property p_parity;
    @(posedge clk) disable iff (!reset_n)
    (rx_valid && rx_result.parity_fault) |=> parity_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not flagged"); // R07

  property p_overrun;
    @(posedge clk) disable iff (!reset_n)
    (rx_valid && ready_q && !rd_hold) |=> overrun_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R08

  property p_ready_clear;
    @(posedge clk) disable iff (!reset_n)
    (rd_hold && !rx_valid) |=> !ready_q;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("data ready stuck"); // R09

  property p_status_clear;
    @(posedge clk) disable iff (!reset_n)
    (rd_status && !rx_valid && !rx_break) |=> !framing_q && !parity_q && !overrun_q;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("errors kept after read"); // R10

  property p_line_irq;
    @(posedge clk) disable iff (!reset_n)
    (irq_mask_q[uart_pkg::IRQ_LINE] && (framing_q || parity_q || overrun_q)) |=> irq_q;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line irq missing"); // R11

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
    (framing_q && !rd_status) |=> framing_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("framing flag lost"); // R12

endmodule : uart_line_core

//--- core/uart_pkg.sv
// shared constants and types for the uart line status block
package uart_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [31:0] HOLDING_OFS    = 32'hffff_0700;
  localparam logic [31:0] DIVISOR_OFS    = 32'hffff_0704;
  localparam logic [31:0] IDENT_OFS      = 32'hffff_0708;
  localparam logic [31:0] LINE_CTRL_OFS  = 32'hffff_070c;
  localparam logic [31:0] CONTROL_TWO_OFS = 32'hffff_0710;
  localparam logic [31:0] LINE_STATUS_OFS = 32'hffff_0714;
  localparam logic [31:0] IRQ_STATUS_OFS = 32'hffff_0718;
  localparam logic [31:0] IRQ_MASK_OFS   = 32'hffff_071c;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          SRC_SEL_LSB     = 6;
  localparam int          LOOPBACK_BIT    = 4;
  localparam int          TWO_STOP_BIT    = 2;
  localparam int          PARITY_EN_BIT   = 3;
  localparam int          PARITY_EVEN_BIT = 4;
  localparam logic [1:0]  SRC_LIN         = 2'h0;
  localparam logic [1:0]  SRC_GP5         = 2'h2;
  localparam logic [7:0]  CONTROL_TWO_RST = 8'h00;
  localparam logic [7:0]  LINE_STATUS_RST = 8'h60;
  localparam logic [4:0]  LINE_CTRL_RST   = 5'h00;
  localparam logic [15:0] DIVISOR_RST     = 16'h0001;
  localparam logic [2:0]  IDENT_NONE      = 3'h1;
  localparam logic [2:0]  IDENT_LINE      = 3'h6;
  localparam logic [2:0]  IDENT_RX        = 3'h4;
  localparam logic [2:0]  IDENT_TX        = 3'h2;
  localparam int          IRQ_LINE        = 0;
  localparam int          IRQ_RX          = 1;
  localparam int          IRQ_TX          = 2;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int          OVERSAMPLE      = 16;
  localparam int          BREAK_BITS      = 12;
  localparam logic [7:0]  BREAK_TICKS     = 8'(BREAK_BITS * OVERSAMPLE);

  typedef struct packed {
    logic unused;
    logic transmitter_fully_empty;
    logic tx_holding_empty;
    logic break_seen;
    logic framing_fault;
    logic parity_fault;
    logic overrun_fault;
    logic rx_data_ready;
  } line_status_s;

  typedef struct packed {
    logic [7:0] data;
    logic       parity_fault;
    logic       framing_fault;
  } rx_result_s;

endpackage : uart_pkg

//--- core/uart_tx_shift.sv
// transmit shift register with start, parity and stop bits
`timescale 1ns/100ps
module uart_tx_shift
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic       parity_en,
  input  wire logic       parity_even,
  input  wire logic       two_stop,
  output logic            serial_q,
  output logic            busy_q
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;

  tx_state_e  state_q;
  logic [3:0] phase_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic       par_q;
  logic       stop_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q  <= TX_IDLE;
      phase_q  <= 4'h0;
      bit_q    <= 3'h0;
      shift_q  <= 8'h00;
      par_q    <= 1'b0;
      stop_q   <= 1'b0;
      serial_q <= 1'b1;
      busy_q   <= 1'b0;
    end
    else if (state_q == TX_IDLE)
    begin
      if (load)
      begin
        state_q  <= TX_START;
        shift_q  <= data;
        par_q    <= ~parity_even ^ (^data);
        phase_q  <= 4'h0;
        busy_q   <= 1'b1;
        serial_q <= 1'b0;
      end
    end
    else if (tick)
    begin
      phase_q <= phase_q + 4'h1;
      if (phase_q == 4'hf)
      begin
        case (state_q)
          TX_START:
          begin
            state_q  <= TX_DATA;
            bit_q    <= 3'h0;
            serial_q <= shift_q[0];
          end
          TX_DATA:
          begin
            shift_q <= {1'b0, shift_q[7:1]};
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              state_q  <= parity_en ? TX_PARITY : TX_STOP;
              serial_q <= parity_en ? par_q : 1'b1;
              stop_q   <= two_stop;
            end
            else
              serial_q <= shift_q[1];
          end
          TX_PARITY:
          begin
            state_q  <= TX_STOP;
            serial_q <= 1'b1;
          end
          TX_STOP:
          begin
            stop_q <= 1'b0;
            if (!stop_q)
            begin
              state_q <= TX_IDLE;
              busy_q  <= 1'b0;
            end
          end
          default: state_q <= TX_IDLE;
        endcase
      end
    end
  end

endmodule : uart_tx_shift

//--- core/uart_rx_frame.sv
// receive framer with parity, stop bit and break checks
`timescale 1ns/100ps
module uart_rx_frame
(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         tick,
  input  wire logic         serial_in,
  input  wire logic         parity_en,
  input  wire logic         parity_even,
  output uart_pkg::rx_result_s result_q,
  output logic              valid_q,
  output logic              break_q
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

  rx_state_e  state_q;
  logic [3:0] phase_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic       pbad_q;
  logic [7:0] low_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q  <= RX_IDLE;
      phase_q  <= 4'h0;
      bit_q    <= 3'h0;
      shift_q  <= 8'h00;
      pbad_q   <= 1'b0;
      result_q <= '0;
      valid_q  <= 1'b0;
    end
    else
    begin
      valid_q <= 1'b0;
      if (tick)
      begin
        phase_q <= phase_q + 4'h1;
        case (state_q)
          RX_IDLE:
          begin
            phase_q <= 4'h0;
            if (!serial_in)
              state_q <= RX_START;
          end
          RX_START:
            if (phase_q == 4'h7)
            begin
              phase_q <= 4'h0;
              bit_q   <= 3'h0;
              pbad_q  <= 1'b0;
              state_q <= serial_in ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (phase_q == 4'hf)
            begin
              shift_q <= {serial_in, shift_q[7:1]};
              bit_q   <= bit_q + 3'h1;
              if (bit_q == 3'h7)
                state_q <= parity_en ? RX_PARITY : RX_STOP;
            end
          RX_PARITY:
            if (phase_q == 4'hf)
            begin
              pbad_q  <= parity_even ? (^shift_q ^ serial_in) : ~(^shift_q ^ serial_in);
              state_q <= RX_STOP;
            end
          RX_STOP:
            if (phase_q == 4'hf)
            begin
              result_q.data          <= shift_q;
              result_q.parity_fault  <= pbad_q;
              result_q.framing_fault <= ~serial_in;
              valid_q                <= 1'b1;
              state_q                <= RX_IDLE;
            end
          default: state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // break: line low longer than the longest frame, one pulse per low spell
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_q   <= 8'h00;
      break_q <= 1'b0;
    end
    else
    begin
      break_q <= 1'b0;
      if (serial_in)
        low_q <= 8'h00;
      else if (tick && low_q != 8'hff)
      begin
        low_q   <= low_q + 8'h01;
        break_q <= (low_q == uart_pkg::BREAK_TICKS);
      end
    end
  end

endmodule : uart_rx_frame

//--- testbench/serial_node.sv
// remote serial node that drives the receive line
`timescale 1ns/100ps
module serial_node
(
  input  wire logic clk,
  output logic      line_q
);
  initial line_q = 1'b1;

  // ****************************************
  // one frame, 16 clocks per bit at divisor one
  // ****************************************
  task automatic send(input logic [7:0] data, input int par, input logic bad_stop);
    logic [10:0] f;
    int          n;
    n = (par > 0) ? 11 : 10;
    f = {2'b11, data, 1'b0};
    if (par > 0)
      f[9] = ^data ^ (par == 2);
    f[n-1] = ~bad_stop;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      line_q <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    line_q <= 1'b1;
  endtask : send

  // line held low past the longest frame
  task automatic hold_low(input int len);
    @(posedge clk);
    line_q <= 1'b0;
    repeat (len) @(posedge clk);
    line_q <= 1'b1;
  endtask : hold_low
endmodule : serial_node

//--- testbench/uart_input_mux_line_status_tb.sv
// self-checking bench for the uart line status block
`timescale 1ns/100ps
module uart_input_mux_line_status_tb;
  localparam logic [31:0] ls   = uart_pkg::LINE_STATUS_OFS;
  localparam logic [31:0] ctl  = uart_pkg::CONTROL_TWO_OFS;
  localparam logic [31:0] hold = uart_pkg::HOLDING_OFS;
  localparam logic [31:0] ist  = uart_pkg::IRQ_STATUS_OFS;
  logic        clk, reset_n, wr_en, rd_en, to_gp5, node_line, tx_pin_q, irq_q;
  logic [31:0] addr, wdata, rdata_q, d;
  logic [7:0]  b;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  uart_line_core uart_line_core_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .lin_rx_pin(to_gp5 | node_line),
    .general_pin_five(~to_gp5 | node_line), .tx_pin_q(tx_pin_q), .irq_q(irq_q));
  serial_node serial_node_i (.clk(clk), .line_q(node_line));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata_q;
  endtask : rd

  function automatic logic [31:0] status_of(input logic [3:0] err, input logic dr);
    return {24'h0, 3'b011, err, dr};
  endfunction : status_of

  task automatic st(input logic [3:0] err, input logic dr);
    rd(ls);
    chk("line_status", status_of(err, dr), d);
  endtask : st

  task automatic frame(input logic [7:0] v, input int par, input logic bad);
    serial_node_i.send(v, par, bad);
    repeat (4) @(posedge clk);
  endtask : frame

  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    reset_n = 1'b0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    addr    = '0;
    wdata   = '0;
    to_gp5  = 1'b0;
    void'($urandom(10260));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(ctl);
    chk("control_two", 32'h0000_0000, d);
    st(4'h0, 1'b0);
    rd(32'hffff_07f0);
    chk("unmapped", 32'h0000_0000, d);
    for (int i = 0; i < 4; i++)
    begin
      wr(ctl, $urandom);
      rd(ctl);
      chk("control_two", wdata & 32'h0000_00d0, d);
    end
    for (int i = 0; i < 8; i++)
    begin
      b = 8'($urandom);
      wr(ctl, {24'h0, i[0], i[1], 6'h0});
      to_gp5 <= i[0];
      frame(b, 0, 1'b0);
      st(4'h0, ~i[1]);
      rd(hold);
      if (!i[1])
        chk("rx_holding", {24'h0, b}, d);
      st(4'h0, 1'b0);
    end
    wr(ctl, 32'h0000_0000);
    to_gp5 <= 1'b0;
    frame(8'h5a, 0, 1'b0);
    frame(b, 0, 1'b0);
    st(4'h1, 1'b1);
    st(4'h0, 1'b1);
    rd(hold);
    chk("rx_holding", {24'h0, b}, d);
    wr(uart_pkg::LINE_CTRL_OFS, 32'h0000_0018);
    frame(b, 2, 1'b0);
    chk("irq_masked", 32'h0, {31'h0, irq_q});
    st(4'h2, 1'b1);
    rd(hold);
    frame(b, 1, 1'b0);
    st(4'h0, 1'b1);
    rd(hold);
    wr(uart_pkg::LINE_CTRL_OFS, 32'h0000_0000);
    wr(ist, 32'h0000_0007);
    wr(uart_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    frame(b, 0, 1'b1);
    chk("irq", 32'h1, {31'h0, irq_q});
    rd(uart_pkg::IDENT_OFS);
    chk("ident", 32'h0000_0006, d);
    st(4'h4, 1'b1);
    st(4'h0, 1'b1);
    wr(ist, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq_q});
    rd(hold);
    serial_node_i.hold_low(16 * 14);
    // long low spell also frames two characters; let the second one land
    repeat (120) @(posedge clk);
    rd(ls);
    chk("break", 32'h1, {31'h0, d[4]});
    rd(hold);
    rd(ls);
    chk("break_cleared", 32'h0, {31'h0, d[4]});
    wr(uart_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    wr(hold, {24'h0, b});
    repeat (4) @(posedge clk);
    chk("tx_start", 32'h0, {31'h0, tx_pin_q});
    rd(ls);
    chk("tx_empty", 32'h1, {30'h0, d[6:5]});
    wr(hold, 32'h0000_00a5);
    rd(ls);
    chk("tx_empty", 32'h0, {30'h0, d[6:5]});
    repeat (340) @(posedge clk);
    st(4'h0, 1'b0);
    wr(ctl, 32'h0000_0010);
    wr(hold, {24'h0, ~b});
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk);
      #1 chk("tx_pin", 32'h1, {31'h0, tx_pin_q});
    end
    rd(hold);
    chk("loop_rx", {24'h0, ~b}, d);
    complete_run();
  end
endmodule : uart_input_mux_line_status_tb
